// [rtl/fpfd_fan_pwm.sv]
// Fan PWM output stage with divisor, duty and lookup table byte registers.
// Notes on behaviour
// R1: The PWM period is twice the divisor field in ticks of the selected base clock.
// R2: The clock select input picks the fast or the slow base clock.
// R3: A divisor of zero produces the same period as a divisor of one.
// R4: Bits 7 to 5 of the divisor register and bits 7 and 6 of the duty register read as zero.
// R5: With direct programming off, the duty register is read-only and shows the duty picked from the table.
// R6: With direct programming on, software writes the duty register and the fan is driven from it.
// R7: During spin-up the duty register reads as zero whatever the pin is doing.
// R8: The table holds eight pairs of a seven-bit threshold and a six-bit duty at 0x50 to 0x5f.
// R9: The top bit of every threshold register reads as zero.
// R10: When the remote temperature exceeds a threshold, the paired duty is used.
// R11: A new divisor or duty takes effect only at the next period boundary.
`timescale 1ns/1ps
module fpfd_fan_pwm
  import fpfd_pkg::*;
#(
  parameter int SLOW_DIV_CYCLES = SLOW_DIV
)
(
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire fpfd_reg_req_t regReq,
  output logic [7:0]         regRdData,
  input  wire logic          fastClkSel,
  input  wire logic          directProg,
  input  wire logic          spinUpActive,
  input  wire logic [5:0]    spinUpDuty,
  input  wire logic [6:0]    remoteTemp,
  output logic               pwmO,
  output logic               pwmOe
);

  function automatic logic lutHit(input logic [7:0] a);
    lutHit = (a >= ADDR_LUT_FIRST) && (a <= ADDR_LUT_LAST);
  endfunction

  function automatic logic divHit(input logic [7:0] a);
    divHit = a == ADDR_DIV;
  endfunction

  function automatic logic dutyHit(input logic [7:0] a);
    dutyHit = a == ADDR_DUTY;
  endfunction

  // A phase is released while its share of full scale stays below the duty share of the period.
  function automatic logic phaseReleased(input logic [5:0] phase, input logic [5:0] duty, input logic [5:0] len);
    phaseReleased = 12'({6'h00, phase} * {6'h00, DUTY_FULL}) < 12'({6'h00, duty} * {6'h00, len});
  endfunction

  logic [4:0]     div_reg,      div_next;
  logic [5:0]     duty_reg,     duty_next;
  logic [6:0]     lutTemp_reg   [LUT_PAIRS];
  logic [6:0]     lutTemp_next  [LUT_PAIRS];
  logic [5:0]     lutDuty_reg   [LUT_PAIRS];
  logic [5:0]     lutDuty_next  [LUT_PAIRS];
  logic [7:0]     rdData_reg,   rdData_next;
  logic [PRE_W-1:0] pre_reg,    pre_next;
  logic [5:0]     phase_reg,    phase_next;
  logic [5:0]     actLen_reg,   actLen_next;
  logic [5:0]     actDuty_reg,  actDuty_next;
  logic           oe_reg,       oe_next;
  logic [LUT_PAIRS-1:0] exceeds;
  logic [5:0]     lutSel;
  logic [5:0]     srcDuty;
  logic [5:0]     readDuty;
  logic [5:0]     newLen;
  logic           baseTick;
  logic [PRE_W-1:0] preLimit;
  logic [2:0]     lutIdx;
  logic           pinData_reg,  pinData_next;

  genvar gi;
  generate
    for (gi = 0; gi < LUT_PAIRS; gi++)
    begin : g_cmp
      assign exceeds[gi] = remoteTemp > lutTemp_reg[gi]; // R10
    end
  endgenerate

  // The highest entry whose threshold is exceeded wins; below every threshold the duty is zero.
  always_comb
  begin
    lutSel = DUTY_RESET;
    for (int i = 0; i < LUT_PAIRS; i++)
    begin
      if (exceeds[i])
      begin
        lutSel = lutDuty_reg[i]; // R10
      end
    end
  end

  assign lutIdx   = regReq.addr[LUT_IDX_MSB:LUT_IDX_LSB];

  // Spin-up overrides the output duty and hides the duty register from reads.
  always_comb
  begin
    if (spinUpActive)
    begin
      srcDuty  = spinUpDuty;
      readDuty = DUTY_RESET; // R7
    end
    else if (directProg)
    begin
      srcDuty  = duty_reg; // R6
      readDuty = duty_reg; // R6
    end
    else
    begin
      srcDuty  = lutSel; // R5
      readDuty = lutSel; // R5
    end
  end

  // Divisor and duty registers; the duty register only takes writes under direct programming.
  always_comb
  begin
    div_next  = div_reg;
    duty_next = duty_reg;
    if (regReq.wrEn && divHit(regReq.addr))
    begin
      div_next = regReq.wrData[4:0];
    end
    if (regReq.wrEn && dutyHit(regReq.addr) && directProg)
    begin
      duty_next = regReq.wrData[5:0]; // R5 R6
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_reg  <= DIV_RESET;
      duty_reg <= DUTY_RESET;
    end
    else
    begin
      div_reg  <= div_next;
      duty_reg <= duty_next;
    end
  end

  // Even table addresses hold the thresholds, odd addresses the paired duties.
  always_comb
  begin
    lutTemp_next = lutTemp_reg;
    lutDuty_next = lutDuty_reg;
    if (regReq.wrEn && lutHit(regReq.addr))
    begin
      if (regReq.addr[LUT_SEL_BIT])
      begin
        lutDuty_next[lutIdx] = regReq.wrData[5:0]; // R8
      end
      else
      begin
        lutTemp_next[lutIdx] = regReq.wrData[6:0]; // R8
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < LUT_PAIRS; i++)
      begin
        lutTemp_reg[i] <= LUT_TEMP_RESET;
        lutDuty_reg[i] <= LUT_DUTY_RESET;
      end
    end
    else
    begin
      lutTemp_reg <= lutTemp_next;
      lutDuty_reg <= lutDuty_next;
    end
  end

  // Read data only moves on a read, so a read that meets a write returns the old value.
  always_comb
  begin
    rdData_next = rdData_reg;
    if (regReq.rdEn)
    begin
      rdData_next = 8'h00;
      if (divHit(regReq.addr))
      begin
        rdData_next = {3'h0, div_reg}; // R4
      end
      else if (dutyHit(regReq.addr))
      begin
        rdData_next = {2'h0, readDuty}; // R4 R7
      end
      else if (lutHit(regReq.addr))
      begin
        if (regReq.addr[LUT_SEL_BIT])
        begin
          rdData_next = {2'h0, lutDuty_reg[lutIdx]};
        end
        else
        begin
          rdData_next = {1'h0, lutTemp_reg[lutIdx]}; // R9
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdData_reg <= 8'h00;
    end
    else
    begin
      rdData_reg <= rdData_next;
    end
  end

  // The prescaler runs freely; a changed clock select takes effect at once.
  assign preLimit = fastClkSel ? PRE_W'(FAST_DIV - 1) : PRE_W'(SLOW_DIV_CYCLES - 1); // R2
  assign baseTick = pre_reg >= preLimit;

  always_comb
  begin
    pre_next = baseTick ? '0 : PRE_W'(pre_reg + 1'b1);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_reg <= '0;
    end
    else
    begin
      pre_reg <= pre_next;
    end
  end

  assign newLen = (div_reg == 5'h00) ? 6'h02 : {div_reg, 1'b0}; // R1 R3

  // Divisor and duty are latched only at the period wrap, so a new divisor or duty never cuts a pulse short.
  always_comb
  begin
    phase_next   = phase_reg;
    actLen_next  = actLen_reg;
    actDuty_next = actDuty_reg;
    if (baseTick)
    begin
      if (phase_reg >= 6'(actLen_reg - 6'h01))
      begin
        phase_next   = 6'h00;
        actLen_next  = newLen; // R11
        actDuty_next = srcDuty; // R11
      end
      else
      begin
        phase_next = 6'(phase_reg + 6'h01); // R1
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_reg   <= 6'h00;
      actLen_reg  <= {DIV_RESET, 1'b0};
      actDuty_reg <= DUTY_RESET;
    end
    else
    begin
      phase_reg   <= phase_next;
      actLen_reg  <= actLen_next;
      actDuty_reg <= actDuty_next;
    end
  end

  // The open-drain pin only ever pulls low; its enable lags the phase by one clock.
  always_comb
  begin
    oe_next      = !phaseReleased(phase_reg, actDuty_reg, actLen_reg);
    pinData_next = 1'b0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      oe_reg      <= 1'b1;
      pinData_reg <= 1'b0;
    end
    else
    begin
      oe_reg      <= oe_next;
      pinData_reg <= pinData_next;
    end
  end

  assign regRdData = rdData_reg;
  assign pwmO      = pinData_reg;
  assign pwmOe     = oe_reg;

endmodule

// [rtl/fpfd_pkg.sv]
// Package with register map, reset values, timing constants and carrier types of the fan PWM stage.
package fpfd_pkg;

  localparam logic [7:0] ADDR_DUTY      = 8'h4c;
  localparam logic [7:0] ADDR_DIV       = 8'h4d;
  localparam logic [7:0] ADDR_LUT_FIRST = 8'h50;
  localparam logic [7:0] ADDR_LUT_LAST  = 8'h5f;

  localparam int         LUT_PAIRS      = 8;
  localparam int         LUT_IDX_LSB    = 1;
  localparam int         LUT_IDX_MSB    = 3;
  localparam int         LUT_SEL_BIT    = 0;

  localparam logic [4:0] DIV_RESET      = 5'h17;
  localparam logic [5:0] DUTY_RESET     = 6'h00;
  localparam logic [6:0] LUT_TEMP_RESET = 7'h7f;
  localparam logic [5:0] LUT_DUTY_RESET = 6'h3f;
  localparam logic [5:0] DUTY_FULL      = 6'h3f;

  localparam int         CLK_HZ         = 125000000;
  localparam int         FAST_BASE_HZ   = 360000;
  localparam int         SLOW_BASE_HZ   = 1400;
  localparam int         FAST_DIV       = (CLK_HZ + FAST_BASE_HZ / 2) / FAST_BASE_HZ;
  localparam int         SLOW_DIV       = (CLK_HZ + SLOW_BASE_HZ / 2) / SLOW_BASE_HZ;
  localparam int         PRE_W          = 17;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrEn;
    logic       rdEn;
  } fpfd_reg_req_t;

endpackage

// [bench/fpfd_fan_model.sv]
// Fan model on the open-drain pin that measures the PWM period.
`timescale 1ns/1ps
module fpfd_fan_model
(
  input  wire logic clk,
  input  wire logic pwmO,
  input  wire logic pwmOe,
  output int        period,
  output int        high
);
  logic line;
  logic lineD = 1'b1;
  int   cnt   = 0;
  int   hCnt  = 0;
  // The pull-up holds the line high whenever the pin is released.
  assign line = (pwmOe && !pwmO) ? 1'b0 : 1'b1;
  always @(posedge clk)
  begin
    lineD <= line;
    cnt   <= (line && !lineD) ? 1 : cnt + 1;
    hCnt  <= (line && !lineD) ? 1 : hCnt + int'(line);
    if (line && !lineD)
    begin
      period <= cnt;
      high   <= hCnt;
    end
  end
endmodule

// [bench/fpfd_fan_pwm_asserts.sv]
// Port assertions of the fan PWM stage.
`timescale 1ns/1ps
module fpfd_fan_pwm_asserts
  import fpfd_pkg::*;
#(parameter int SLOW_DIV_CYCLES = SLOW_DIV)
(
  input wire logic          clk,
  input wire logic          nrst,
  input wire fpfd_reg_req_t regReq,
  input wire logic [7:0]    regRdData,
  input wire logic          fastClkSel,
  input wire logic          directProg,
  input wire logic          spinUpActive,
  input wire logic [5:0]    spinUpDuty,
  input wire logic [6:0]    remoteTemp,
  input wire logic          pwmO,
  input wire logic          pwmOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rdA;
  logic lut;
  assign rdA = regReq.rdEn && regReq.addr == ADDR_DUTY;
  assign lut = regReq.rdEn && regReq.addr >= ADDR_LUT_FIRST && regReq.addr <= ADDR_LUT_LAST;
  a_pin_lowonly: assert property (pwmO == 1'b0) else $error("pin high");
  a_div_upper: assert property (regReq.rdEn && regReq.addr == ADDR_DIV |=> regRdData[7:5] == 3'h0)
    else $error("div bits");
  a_duty_upper: assert property (rdA |=> regRdData[7:6] == 2'h0) else $error("duty bits");
  a_spin_zero: assert property (rdA && spinUpActive |=> regRdData == 8'h00) else $error("spin read");
  a_temp_top: assert property (lut && !regReq.addr[0] |=> !regRdData[7]) else $error("temp bit");
  a_lut_duty: assert property (lut && regReq.addr[0] |=> regRdData[7:6] == 2'h0) else $error("lut duty");
  a_table_none: assert property (rdA && !spinUpActive && !directProg && remoteTemp == 7'h00
    |=> regRdData == 8'h00) else $error("table read");
  a_rd_hold: assert property (!regReq.rdEn |=> $stable(regRdData)) else $error("read moved");
  a_direct_write: assert property (directProg && regReq.wrEn && !regReq.rdEn && regReq.addr == ADDR_DUTY
    ##1 rdA && directProg && !spinUpActive && !regReq.wrEn
    |=> regRdData == ($past(regReq.wrData, 2) & 8'h3f)) else $error("direct duty");
  c_spin: cover property (rdA && spinUpActive);
  c_direct: cover property (directProg && regReq.wrEn);
  c_release: cover property ($fell(pwmOe));
endmodule
bind fpfd_fan_pwm fpfd_fan_pwm_asserts #(.SLOW_DIV_CYCLES(SLOW_DIV_CYCLES)) i_chk(.clk(clk), .nrst(nrst),
  .regReq(regReq), .regRdData(regRdData), .fastClkSel(fastClkSel), .directProg(directProg),
  .spinUpActive(spinUpActive), .spinUpDuty(spinUpDuty), .remoteTemp(remoteTemp), .pwmO(pwmO), .pwmOe(pwmOe));

// [bench/fan_pwm_frequency_and_duty_test.sv]
// Self-checking testbench of the fan PWM stage.
`timescale 1ns/1ps
module fan_pwm_frequency_and_duty_test import fpfd_pkg::*;;
  localparam int SLOW_CYC = 20;
  logic clk = 1'b0, nrst = 1'b0, fastClkSel = 1'b0, directProg = 1'b0, spinUpActive = 1'b0, pwmO, pwmOe;
  logic [5:0] spinUpDuty = 6'h0;
  logic [6:0] remoteTemp = 7'h0;
  logic [7:0] regRdData, rv, th, d;
  logic [4:0] ns [4] = '{5'h0, 5'h1, 5'h3, 5'h1};
  fpfd_reg_req_t regReq = '0;
  int failures = 0, compares = 0, period, high;
  always #4 clk = ~clk;
  fpfd_fan_pwm #(.SLOW_DIV_CYCLES(SLOW_CYC)) i_dut(.clk(clk), .nrst(nrst), .regReq(regReq), .regRdData(regRdData),
    .fastClkSel(fastClkSel), .directProg(directProg), .spinUpActive(spinUpActive), .spinUpDuty(spinUpDuty),
    .remoteTemp(remoteTemp), .pwmO(pwmO), .pwmOe(pwmOe));
  fpfd_fan_model i_fan(.clk(clk), .pwmO(pwmO), .pwmOe(pwmOe), .period(period), .high(high));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic [7:0] wd, input logic w, input logic r);
    regReq = '{a, wd, w, r};
    @(negedge clk);
    rv = regRdData;
  endtask
  function automatic int expPeriod(input logic [4:0] n, input logic f);
    return 2 * ((n == 5'h0) ? 1 : n) * (f ? FAST_DIV : SLOW_CYC);
  endfunction
  // Released time per period: phases whose share of full scale is below the duty share.
  function automatic int expHigh(input logic [4:0] n, input logic f, input logic [5:0] dv);
    int len;
    int hits;
    len  = 2 * ((n == 5'h0) ? 1 : n);
    hits = 0;
    for (int p = 0; p < len; p++)
      if (p * int'(DUTY_FULL) < int'(dv) * len)
        hits++;
    return hits * (f ? FAST_DIV : SLOW_CYC);
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400000;
    failures++;
    final_report();
  end
  initial
  begin
    void'($urandom(77));
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    acc(ADDR_DIV, 8'h0, 1'b0, 1'b1); chk(rv, {3'h0, DIV_RESET});
    acc(8'h50, 8'h0, 1'b0, 1'b1); chk(rv, {1'b0, LUT_TEMP_RESET});
    acc(8'h51, 8'h0, 1'b0, 1'b1); chk(rv, {2'h0, LUT_DUTY_RESET});
    acc(ADDR_DIV, 8'hff, 1'b1, 1'b0); acc(ADDR_DIV, 8'h0, 1'b0, 1'b1); chk(rv, 8'h1f);
    acc(ADDR_DUTY, 8'($urandom), 1'b1, 1'b0); acc(ADDR_DUTY, 8'h0, 1'b0, 1'b1); chk(rv, 8'h00);
    $display("register test done");
    directProg = 1'b1;
    repeat (8)
    begin
      d = 8'($urandom);
      acc(ADDR_DUTY, d, 1'b1, 1'b0); acc(ADDR_DUTY, 8'h0, 1'b0, 1'b1); chk(rv, d & 8'h3f);
    end
    spinUpActive = 1'b1;
    acc(ADDR_DUTY, 8'h0, 1'b0, 1'b1); chk(rv, 8'h00);
    spinUpActive = 1'b0;
    $display("direct test done");
    directProg = 1'b0;
    th = 8'($urandom) & 8'h3f;
    d = 8'($urandom);
    acc(8'h56, th | 8'h80, 1'b1, 1'b0); acc(8'h57, d, 1'b1, 1'b0);
    acc(8'h56, 8'h0, 1'b0, 1'b1); chk(rv, th);
    acc(8'h57, 8'h0, 1'b0, 1'b1); chk(rv, d & 8'h3f);
    remoteTemp = th[6:0] + 7'h1;
    repeat (2) acc(ADDR_DUTY, 8'h0, 1'b0, 1'b1);
    chk(rv, d & 8'h3f);
    remoteTemp = th[6:0];
    repeat (2) acc(ADDR_DUTY, 8'h0, 1'b0, 1'b1);
    chk(rv, 8'h00);
    $display("table test done");
    directProg = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      fastClkSel   = (i == 3);
      spinUpActive = (i == 2);
      d            = 8'(1 + $urandom % 31);
      spinUpDuty   = d[5:0];
      acc(ADDR_DUTY, (i == 2) ? (d ^ 8'h3f) : d, 1'b1, 1'b0);
      acc(ADDR_DUTY, 8'h0, 1'b0, 1'b1);
      chk(rv, (i == 2) ? 8'h00 : d);
      acc(ADDR_DIV, {3'h0, ns[i]}, 1'b1, 1'b0);
      repeat (1500 + 3 * expPeriod(ns[i], i == 3)) @(negedge clk);
      chk(period, expPeriod(ns[i], i == 3));
      chk(high, expHigh(ns[i], i == 3, d[5:0]));
    end
    spinUpActive = 1'b0;
    $display("period test done");
    final_report();
  end
endmodule
